// *** core/asw_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asw_params.svh"
module asw_top
   import asw_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // sample sources, all synchronous to clock
   input wire logic [2:0] src_sel,
   input wire logic [5:0] src_index,
   input wire logic [10:0] ain_values [8],
   input wire logic signed [15:0] mark_values [64],
   input wire logic signed [15:0] nain_values [32],
   input wire logic signed [15:0] aout_values [8],
   input wire logic signed [15:0] naout_values [16],
   input wire logic signed [15:0] block_value,
   // arm input
   input wire logic watch_arm,
   // parameters
   input wire logic signed [15:0] gain,
   input wire logic signed [15:0] offset,
   input wire logic [15:0] upper_margin,
   input wire logic [15:0] lower_margin,
   input wire logic upper_from_block,
   input wire logic lower_from_block,
   input wire logic [15:0] upper_block_value,
   input wire logic [15:0] lower_block_value,
   input wire logic [1:0] decimals,
   input wire logic retain_enable,
   // outputs
   output logic watchdog_output,
   output logic signed [15:0] scaled_output,
   output logic signed [15:0] stored_reference,
   output logic param_error,
   output logic [1:0] display_decimals
);
   logic signed [31:0] raw_sample;
   logic signed [31:0] ref_raw_ff, nxt_ref_raw;
   logic signed [15:0] gain_ff, nxt_gain;
   logic signed [15:0] offs_ff, nxt_offs;
   logic [15:0] up_ff, nxt_up;
   logic [15:0] lo_ff, nxt_lo;
   logic arm_ff, nxt_arm;
   logic wd_ff, nxt_wd;
   logic signed [15:0] out_ff, nxt_out;
   logic signed [15:0] sref_ff, nxt_sref;
   logic err_ff, nxt_err;
   logic [1:0] dec_ff, nxt_dec;
   asw_state_t state_ff, nxt_state;
   logic signed [31:0] live_scaled;
   logic signed [31:0] ref_scaled;
   logic [15:0] up_sel, lo_sel;
   logic signed [31:0] win_hi, win_lo;
   logic gain_ok, offs_ok, up_ok, lo_ok, outside;
   logic above, below, arm_rise;
   logic signed [31:0] ain_raw;
   logic signed [31:0] ain_clip;

   // physical inputs clipped to 0..1000
   // a stray count above full scale must not reach the multiplier
   always_comb
   begin
      ain_raw = 32'(ain_values[src_index[2:0]]);
      if (ain_raw > `ASW_PHYS_MAX)
         ain_clip = `ASW_PHYS_MAX;
      else
         ain_clip = ain_raw;
   end

   always_comb
   begin
      unique case (asw_src_t'(src_sel))
         ASW_SRC_AIN: raw_sample = ain_clip;
         ASW_SRC_MARK: raw_sample = 32'(mark_values[src_index]);
         ASW_SRC_NAIN: raw_sample = 32'(nain_values[src_index[4:0]]);
         ASW_SRC_AOUT: raw_sample = 32'(aout_values[src_index[2:0]]);
         ASW_SRC_NAOUT: raw_sample = 32'(naout_values[src_index[3:0]]);
         default: raw_sample = 32'(block_value);
      endcase
   end

   assign gain_ok = (32'(gain) >= `ASW_GAIN_MIN) &&
      (32'(gain) <= `ASW_GAIN_MAX);
   assign offs_ok = (32'(offset) >= `ASW_OFFS_MIN) &&
      (32'(offset) <= `ASW_OFFS_MAX);
   assign up_sel = upper_from_block ? upper_block_value : upper_margin;
   assign lo_sel = lower_from_block ? lower_block_value : lower_margin;
   assign up_ok = (32'(up_sel) <= `ASW_MARGIN_MAX);
   assign lo_ok = (32'(lo_sel) <= `ASW_MARGIN_MAX);

   asw_scale u_live
   (
      .value(raw_sample),
      .gain(gain_ff),
      .offset(offs_ff),
      .result(live_scaled)
   );
   asw_scale u_ref
   (
      .value(ref_raw_ff),
      .gain(gain_ff),
      .offset(offs_ff),
      .result(ref_scaled)
   );

   // 32 bits: reference plus full margin cannot overflow
   always_comb
   begin
      win_hi = ref_scaled + 32'(up_ff);
      win_lo = ref_scaled - 32'(lo_ff);
      above = live_scaled > win_hi;
      below = live_scaled < win_lo;
      outside = above || below;
   end

   // rising arm; a cleared flop re-captures a held arm
   assign arm_rise = watch_arm && !arm_ff;

   // watch group: reference, arm, alarm and accepted settings
   always_comb
   begin
      nxt_arm = watch_arm;
      nxt_state = state_ff;
      nxt_ref_raw = ref_raw_ff;
      nxt_wd = 1'b0;
      // out-of-span settings are refused, last good value kept
      nxt_gain = gain_ok ? gain : gain_ff;
      nxt_offs = offs_ok ? offset : offs_ff;
      nxt_up = up_ok ? up_sel : up_ff;
      nxt_lo = lo_ok ? lo_sel : lo_ff;
      if (arm_rise)
      begin
         nxt_ref_raw = raw_sample;
         nxt_state = ASW_ARMED;
      end
      else if (!watch_arm)
      begin
         nxt_state = ASW_IDLE;
      end
      unique case (state_ff)
         ASW_ARMED: nxt_wd = watch_arm && arm_ff && outside;
         ASW_IDLE: nxt_wd = 1'b0;
         default: nxt_wd = 1'b0;
      endcase
   end

   // output group
   always_comb
   begin
      nxt_err = !(gain_ok && offs_ok && up_ok && lo_ok);
      nxt_dec = decimals;
      nxt_out = live_scaled[15:0];
      nxt_sref = ref_scaled[15:0];
   end

   // retained group frozen while reset is held with retain_enable set, cleared without it
   // settings kept too, so the window is whole at release
   always_ff @(posedge clock)
   begin
      if (reset && !retain_enable)
      begin
         ref_raw_ff <= 32'sh0;
         state_ff <= ASW_IDLE;
         wd_ff <= 1'b0;
         arm_ff <= 1'b0;
         gain_ff <= 16'sh0;
         offs_ff <= 16'sh0;
         up_ff <= 16'h0;
         lo_ff <= 16'h0;
      end
      else if (!reset)
      begin
         ref_raw_ff <= nxt_ref_raw;
         state_ff <= nxt_state;
         wd_ff <= nxt_wd;
         arm_ff <= nxt_arm;
         gain_ff <= nxt_gain;
         offs_ff <= nxt_offs;
         up_ff <= nxt_up;
         lo_ff <= nxt_lo;
      end
      // reset with retention falls through: every value held
   end

   // outputs restart from zero on any reset
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         out_ff <= 16'sh0;
         sref_ff <= 16'sh0;
         err_ff <= 1'b0;
         dec_ff <= 2'h0;
      end
      else
      begin
         out_ff <= nxt_out;
         sref_ff <= nxt_sref;
         err_ff <= nxt_err;
         dec_ff <= nxt_dec;
      end
   end

   assign watchdog_output = wd_ff;
   assign scaled_output = out_ff;
   assign stored_reference = sref_ff;
   assign param_error = err_ff;
   assign display_decimals = dec_ff;
endmodule
`default_nettype wire

// *** core/asw_params.svh ***
// Summary of operation
// - Rising edge of watch_arm captures raw_sample as stored reference.
// - Live and stored samples both scaled: times gain, then plus offset.
// - Armed alarm asserts when scaled live value leaves reference window.
// - Alarm clears when value returns inside window or arm drops.
// - Gain is signed hundredths, accepted only within -10.00 to +10.00.
// - Offset is signed integer, accepted only within -10000 to +10000.
// - Amplifier outputs scaled raw_sample unchanged on scaled_output.
// - scaled_output spans -32767 to +32767.
// - Physical analog inputs are integers 0 to 1000 before scaling.
// - Decimal places setting affects display only, never computation.
// - raw_sample source chosen among inputs, outputs, markers, network or blocks.
// - Margins are integers 0 to 20000, possibly another block's value.
// - With retention enabled state survives restart, else it clears.
`ifndef ASW_PARAMS_SVH
`define ASW_PARAMS_SVH
`define ASW_GAIN_MIN (-32'sd1000)
`define ASW_GAIN_MAX (32'sd1000)
`define ASW_GAIN_DIV (32'sd100)
`define ASW_OFFS_MIN (-32'sd10000)
`define ASW_OFFS_MAX (32'sd10000)
`define ASW_MARGIN_MAX (32'sd20000)
`define ASW_OUT_MIN (-32'sd32767)
`define ASW_OUT_MAX (32'sd32767)
`define ASW_PHYS_MAX (32'sd1000)
`define ASW_DEC_MAX (2'd3)
`define ASW_SRC_COUNT 6
`endif

// *** core/asw_pkg.sv ***
package asw_pkg;
   typedef enum logic [1:0]
   {
      ASW_IDLE = 2'b00,
      ASW_ARMED = 2'b01
   } asw_state_t;
   // source group of raw_sample
   typedef enum logic [2:0]
   {
      ASW_SRC_AIN = 3'h0,
      ASW_SRC_MARK = 3'h1,
      ASW_SRC_NAIN = 3'h2,
      ASW_SRC_AOUT = 3'h3,
      ASW_SRC_NAOUT = 3'h4,
      ASW_SRC_BLOCK = 3'h5
   } asw_src_t;
endpackage

// *** core/asw_scale.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asw_params.svh"
module asw_scale
(
   // operands
   input wire logic signed [31:0] value,
   input wire logic signed [15:0] gain,
   input wire logic signed [15:0] offset,
   // result, saturated to output span
   output logic signed [31:0] result
);
   logic signed [47:0] prod;
   logic signed [47:0] sum;
   always_comb
   begin
      prod = (48'(value) * 48'(gain)) / 48'(`ASW_GAIN_DIV);
      sum = prod + 48'(offset);
      if (sum > 48'(`ASW_OUT_MAX))
         result = `ASW_OUT_MAX;
      else if (sum < 48'(`ASW_OUT_MIN))
         result = `ASW_OUT_MIN;
      else
         result = sum[31:0];
   end
endmodule
`default_nettype wire

// *** sim/asw_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module asw_assertions
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // watched ports
   input wire logic watch_arm,
   input wire logic retain_enable,
   input wire logic signed [15:0] gain,
   input wire logic signed [15:0] offset,
   input wire logic [15:0] upper_margin,
   input wire logic upper_from_block,
   input wire logic [1:0] decimals,
   input wire logic watchdog_output,
   input wire logic signed [15:0] scaled_output,
   input wire logic param_error,
   input wire logic [1:0] display_decimals
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   sequence arm_off;
      !watch_arm[*2];
   endsequence
   disp_copy_a: assert property (
      1 |=> display_decimals == $past(decimals))
      else $error("display decimals wrong");
   arm_clear_a: assert property (arm_off |=> !watchdog_output)
      else $error("alarm while disarmed");
   gain_span_a: assert property (
      (gain > 16'sh03e8 || gain < -16'sh03e8) |=> param_error)
      else $error("gain out of span accepted");
   offs_span_a: assert property (
      (offset > 16'sh2710 || offset < -16'sh2710) |=> param_error)
      else $error("offset out of span accepted");
   marg_span_a: assert property (
      !upper_from_block && upper_margin > 16'h4e20 |=> param_error)
      else $error("margin out of span accepted");
   out_sat_a: assert property (scaled_output != 16'sh8000)
      else $error("output beyond span");
   reset_clr_a: assert property (disable iff (1'b0)
      reset && !retain_enable |=>
         !watchdog_output && scaled_output == 16'sh0000)
      else $error("reset left state");
   retain_hold_a: assert property (disable iff (1'b0)
      reset && retain_enable |=> $stable(watchdog_output))
      else $error("retained alarm lost");
endmodule
bind asw_top asw_assertions u_chk (.clock(clock), .reset(reset),
   .watch_arm(watch_arm), .retain_enable(retain_enable), .gain(gain),
   .offset(offset), .upper_margin(upper_margin), .decimals(decimals),
   .upper_from_block(upper_from_block),
   .watchdog_output(watchdog_output), .scaled_output(scaled_output),
   .param_error(param_error), .display_decimals(display_decimals));
`default_nettype wire

// *** sim/asw_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module asw_src_model
(
   // level from bench
   input wire logic signed [15:0] level,
   // analog sources
   output logic [10:0] ain_values [8],
   output logic signed [15:0] mark_values [64],
   output logic signed [15:0] nain_values [32],
   output logic signed [15:0] aout_values [8],
   output logic signed [15:0] naout_values [16],
   output logic signed [15:0] block_value
);
   // inputs clipped, groups offset so selection shows
   // real outputs carry 0..1000 only, so they are clipped too
   always_comb
   begin
      foreach (ain_values[i]) ain_values[i] = (level + 16'(i) > 16'sh03e8) ?
         11'h3e8 : 11'(level + 16'(i));
      foreach (mark_values[i]) mark_values[i] = level + 16'(i) + 16'sh0001;
      foreach (nain_values[i]) nain_values[i] = level + 16'(i) + 16'sh0002;
      foreach (aout_values[i]) aout_values[i] =
         (level + 16'(i) + 16'sh0003 > 16'sh03e8) ?
         16'sh03e8 : level + 16'(i) + 16'sh0003;
      foreach (naout_values[i]) naout_values[i] = level + 16'(i) + 16'sh0004;
      block_value = level + 16'sh0005;
   end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock, reset, watch_arm, retain_enable, wo, perr;
   logic [2:0] src_sel;
   logic [1:0] decimals, dd;
   logic [15:0] um, lm, ubv, lbv;
   logic ufb, lfb;
   logic signed [15:0] gain, offset, level, so, sr, bv;
   logic [10:0] ai [8];
   logic signed [15:0] mk [64], ni [32], ao [8], nq [16];
   int n_fail = 0, compares = 0, cyc = 0;
   int tl[4] = '{997, 996, 20000, 20000}, tg[4] = '{1000, -1, 1000, -1000};
   int to[4] = '{10000, 0, 0, -10000}, te[4] = '{20000, -9, 32767, -32767};
   int wl[5] = '{507, 508, 487, 486, 497}, we[5] = '{0, 1, 0, 1, 0};
   asw_src_model u_src (.level(level), .ain_values(ai), .mark_values(mk),
      .nain_values(ni), .aout_values(ao), .naout_values(nq), .block_value(bv));
   asw_top DUT (.clock(clock), .reset(reset), .src_sel(src_sel),
      .src_index(6'h03), .ain_values(ai), .mark_values(mk), .nain_values(ni),
      .aout_values(ao), .naout_values(nq), .block_value(bv),
      .watch_arm(watch_arm), .gain(gain), .offset(offset), .upper_margin(um),
      .lower_margin(lm), .upper_from_block(ufb), .lower_from_block(lfb),
      .upper_block_value(ubv), .lower_block_value(lbv),
      .decimals(decimals), .retain_enable(retain_enable),
      .watchdog_output(wo), .scaled_output(so), .stored_reference(sr),
      .param_error(perr), .display_decimals(dd));
   task chk(input logic signed [31:0] got, input logic signed [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task w(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   task close_out;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // hang guard: whole sequence needs about 160 cycles
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_fail++;
         close_out;
      end
   end
   initial
   begin
      reset = 1'b1; watch_arm = 1'b0; retain_enable = 1'b0; src_sel = 3'h0;
      decimals = 2'h0; um = 16'h000a; lm = 16'h000a;
      ufb = 1'b0;
      lfb = 1'b0;
      ubv = 16'h0000;
      lbv = 16'h0000;
      gain = 16'sh0064; offset = 16'sh0000; level = 16'sh01f4;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      for (int s = 0; s < 6; s++)
      begin
         @(posedge clock);
         src_sel <= 3'(s);
         w(4);
         chk(so, s == 5 ? 505 : 503 + s);
      end
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clock);
         src_sel <= i < 2 ? 3'h0 : 3'h5;
         level <= 16'(tl[i]);
         gain <= 16'(tg[i]);
         offset <= 16'(to[i]);
         w(4);
         chk(so, te[i]);
      end
      @(posedge clock);
      gain <= 16'sh03e9;
      w(4);
      chk(perr, 1);
      chk(so, -32767);
      @(posedge clock);
      gain <= -16'sh03e8;
      offset <= 16'sh2711;
      w(4);
      chk(perr, 1);
      @(posedge clock);
      offset <= -16'sh2710;
      um <= 16'h4e21;
      w(4);
      chk(perr, 1);
      @(posedge clock);
      um <= 16'h000a;
      w(4);
      chk(perr, 0);
      for (int d = 0; d < 4; d++)
      begin
         @(posedge clock);
         decimals <= 2'(d);
         w(3);
         chk(dd, d);
         chk(so, -32767);
      end
      @(posedge clock);
      src_sel <= 3'h0;
      gain <= 16'sh0064;
      offset <= 16'sh0000;
      level <= 16'sh01f1;
      watch_arm <= 1'b1;
      w(4);
      chk(sr, 500);
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clock);
         level <= 16'(wl[i]);
         w(4);
         chk(wo, we[i]);
      end
      @(posedge clock);
      level <= 16'sh01e6;
      watch_arm <= 1'b0;
      w(4);
      chk(wo, 0);
      @(posedge clock);
      watch_arm <= 1'b1;
      w(3);
      @(posedge clock);
      level <= 16'sh01f1;
      w(4);
      chk(wo, 1);
      // block-fed upper margin widens the window to take 500 in
      @(posedge clock);
      ubv <= 16'h000b;
      ufb <= 1'b1;
      w(4);
      chk(wo, 0);
      // block-fed lower margin out of span is refused, old 10 kept
      @(posedge clock);
      lbv <= 16'h4e21;
      lfb <= 1'b1;
      level <= 16'sh01db;
      w(4);
      chk(perr, 1);
      chk(wo, 1);
      @(posedge clock);
      retain_enable <= 1'b1;
      reset <= 1'b1;
      w(3);
      chk(wo, 1);
      @(posedge clock);
      retain_enable <= 1'b0;
      w(2);
      chk(wo, 0);
      // release: cleared arm flop sees the held arm as a new rise
      @(posedge clock);
      reset <= 1'b0;
      w(4);
      chk(so, 478);
      chk(sr, 478);
      close_out;
   end
endmodule
`default_nettype wire
